//--- hw/dcr_map.svh
// constants for the dual clock ram clocking block
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
`define DCR_ADDR_W     9
`define DCR_DATA_W     8
`define DCR_MODE_IO    2'h0
`define DCR_MODE_RW    2'h1
`define DCR_MODE_SP    2'h2
`define DCR_MODE_SP2   2'h3
`define DCR_SEL_CLK0   1'h0
`define DCR_SEL_CLK1   1'h1
`define DCR_CLR_VAL    1'h0
`endif

//--- hw/dcr_pkg.sv
// types for the dual clock ram clocking block
`include "dcr_map.svh"
package dcr_pkg;
   typedef enum logic [1:0] {
      DCR_IO  = `DCR_MODE_IO,
      DCR_RW  = `DCR_MODE_RW,
      DCR_SP  = `DCR_MODE_SP,
      DCR_SP2 = `DCR_MODE_SP2
   } dcr_mode_t;

   // one port's request as seen by the input registers
   typedef struct packed {
      logic                   wren;
      logic                   rden;
      logic [`DCR_ADDR_W-1:0] addr;
      logic [`DCR_DATA_W-1:0] data;
   } dcr_req_t;

   // per-port clock enables and clears, input side and output side
   typedef struct packed {
      logic ce_in;
      logic ce_out;
      logic clr_in;
      logic clr_out;
   } dcr_ctl_t;
endpackage

//--- hw/dcr_ram.sv
// dual port ram with selectable input/output, read/write and single port clocking
`timescale 1ns/10ps
`include "dcr_map.svh"
module dcr_ram (
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   clk0_en_i,
   input  wire logic                   clk1_en_i,
   input  dcr_pkg::dcr_mode_t          mode_i,
   input  dcr_pkg::dcr_req_t           req_a_i,
   input  dcr_pkg::dcr_req_t           req_b_i,
   input  dcr_pkg::dcr_ctl_t           ctl_a_i,
   input  dcr_pkg::dcr_ctl_t           ctl_b_i,
   output logic      [`DCR_DATA_W-1:0] dout_a_o,
   output logic      [`DCR_DATA_W-1:0] dout_b_o
);
   import dcr_pkg::*;

   // sizes follow the header widths; split mode gives each port half of DEPTH
   localparam int AW    = `DCR_ADDR_W;
   localparam int DW    = `DCR_DATA_W;
   localparam int DEPTH = 1 << AW;
   localparam int IN_W  = 1 + AW + DW;

   // the top keeps only the reset synchroniser; each side's registers live in the banks below
   typedef struct packed {
      logic [1:0] rst_sync;
   } dcr_top_st_t;

   dcr_top_st_t st_ff;
   dcr_top_st_t nxt_st;
   logic        rst_n;

   // reset release through two flops
   // the external reset takes hold at once, but its release is moved onto a clock edge
   // so that no register leaves reset a fraction of a cycle before its neighbour
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // internal reset, low until the second edge after the external release
   assign rst_n = st_ff.rst_sync[1];

   // storage has no reset on purpose: a word reads undefined until first written,
   // and neither reset nor the side clears reach it, only enabled writes do
   logic [DW-1:0] mem [DEPTH];

   // per-port working signals, index 0 is port a and index 1 is port b
   dcr_req_t      req     [2];
   dcr_ctl_t      ctl     [2];
   logic          in_sel  [2];
   logic          out_sel [2];
   logic          wr_ok   [2];
   logic          in_en   [2];
   logic          out_en  [2];
   logic          in_clr  [2];
   logic [IN_W-1:0] in_q  [2];
   logic          rden_q  [2];
   logic [AW-1:0] addr_q  [2];
   logic [AW-1:0] waddr   [2];
   logic [DW-1:0] dout_q  [2];
   logic          rd_go   [2];
   // per-side ticks, off flags and the gated write strobe
   logic          tk_in   [2];
   logic          tk_out  [2];
   logic          in_off  [2];
   logic          out_off [2];
   logic          wr_go   [2];

   // fold both ports into arrays so that one loop can serve them
   assign req[0] = req_a_i;
   assign req[1] = req_b_i;
   assign ctl[0] = ctl_a_i;
   assign ctl[1] = ctl_b_i;

   // per-mode choice of clock for each side of each port
   // both clocks are tick enables on the system clock; each side picks the one it follows
   always_comb begin
      in_sel[0]  = `DCR_SEL_CLK0;
      in_sel[1]  = `DCR_SEL_CLK0;
      out_sel[0] = `DCR_SEL_CLK1;
      out_sel[1] = `DCR_SEL_CLK1;
      wr_ok[0]   = 1'b1;
      wr_ok[1]   = 1'b1;
      case (mode_i)
         DCR_IO: begin
            // inputs on clock 0, outputs on clock 1, both ports
            in_sel[0] = `DCR_SEL_CLK0;
         end
         DCR_RW: begin
            // port a writes on clock 0, port b reads on clock 1
            in_sel[1] = `DCR_SEL_CLK1;
            // port b is the read side only, its write requests are dropped
            wr_ok[1]  = 1'b0;
         end
         DCR_SP: begin
            // one clock, one address, port b idle
            // port a reads back on clock 0 as well
            out_sel[0] = `DCR_SEL_CLK0;
            wr_ok[1]   = 1'b0;
         end
         DCR_SP2: begin
            // two independent single-port rams, each on its own clock
            out_sel[0] = `DCR_SEL_CLK0;
            in_sel[1]  = `DCR_SEL_CLK1;
         end
         default: begin
            // not reachable with a two-bit mode; keep both ports from writing if it ever is
            wr_ok[0] = 1'b0;
            wr_ok[1] = 1'b0;
         end
      endcase
   end

   // one loop builds both ports: p = 0 is port a, p = 1 is port b
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         // tick of whichever clock this side follows in the current mode
         assign tk_in[p]   = (in_sel[p] == `DCR_SEL_CLK1) ? clk1_en_i : clk0_en_i;
         assign tk_out[p]  = (out_sel[p] == `DCR_SEL_CLK1) ? clk1_en_i : clk0_en_i;
         // port b is off in single port mode; port a has no read side in read/write mode
         assign in_off[p]  = (mode_i == DCR_SP) && (p == 1);
         assign out_off[p] = in_off[p] || ((mode_i == DCR_RW) && (p == 0));
         // enables gate the chosen clock tick with that side's own enable
         assign in_en[p]   = tk_in[p] & ctl[p].ce_in & !in_off[p];
         assign out_en[p]  = tk_out[p] & ctl[p].ce_out & !out_off[p];
         // read side of port b in read/write mode clears with its output clear
         assign in_clr[p] = (mode_i == DCR_RW && p == 1) ? ctl[p].clr_out : ctl[p].clr_in;

         // a held input clear blocks the captured write enable and the array write alike
         assign wr_go[p]   = in_en[p] & req[p].wren & wr_ok[p] & !in_clr[p];

         // in split mode the port index replaces the top address bit to pick the half
         // each half holds 256 words of 8 bits, so neither ram exceeds 2K bits
         assign waddr[p] = (mode_i == DCR_SP2) ? {1'(p), req[p].addr[AW-2:0]} : req[p].addr;

         // write enable, address and data captured together
         dcr_regbank #(
            .W         (IN_W),
            .CLEARABLE (1'b1)
         ) u_in (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n),
            .clr_i     (in_clr[p]),
            .en_i      (in_en[p]),
            .d_i       ({req[p].wren & wr_ok[p], waddr[p], req[p].data}),
            .q_o       (in_q[p])
         );

         // read enable register has no asynchronous clear
         // it leaves reset with the rest, but a side clear leaves a pending read request standing
         dcr_regbank #(
            .W         (1),
            .CLEARABLE (1'b0)
         ) u_rden (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n),
            .clr_i     (1'b0),
            .en_i      (in_en[p]),
            .d_i       (req[p].rden),
            .q_o       (rden_q[p])
         );

         // address part of the captured input word selects the word to read
         assign addr_q[p] = in_q[p][AW+DW-1:DW];
         // read enable only gates reads in read/write mode
         // in the other modes every enabled output edge reads and the read enable is ignored
         assign rd_go[p]  = out_en[p] & ((mode_i != DCR_RW) | rden_q[p]);

         // read data register on the output clock
         // this bank is the only path to the outputs, so dout always comes straight from a flop
         dcr_regbank #(
            .W         (DW),
            .CLEARABLE (1'b1)
         ) u_out (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n),
            .clr_i     (ctl[p].clr_out),
            .en_i      (rd_go[p]),
            .d_i       (mem[addr_q[p]]),
            .q_o       (dout_q[p])
         );
      end
   endgenerate

   // array written at the capturing edge; clears never touch it; port a wins a collision
   // port b is written first in the loop, so port a's write lands last when both name one address
   // the output banks sample the array before this edge's write lands: a same-edge read returns old data
   always_ff @(posedge clk_sys_i) begin
      for (int i = 1; i >= 0; i--) begin
         if (wr_go[i]) begin
            mem[waddr[i]] <= req[i].data;
         end
      end
   end

   // outputs straight from the read data banks
   assign dout_a_o = dout_q[0];
   assign dout_b_o = dout_q[1];
endmodule

//--- hw/dcr_regbank.sv
// register bank with clock enable and optional asynchronous clear
`timescale 1ns/10ps
module dcr_regbank #(
   parameter int W         = 8,
   parameter bit CLEARABLE = 1'b1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic         clr_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   import dcr_pkg::*;

   typedef struct packed {
      logic [W-1:0] q;
   } dcr_bank_st_t;

   dcr_bank_st_t st_ff;
   dcr_bank_st_t nxt_st;

   // hold while the enable is low
   always_comb begin
      nxt_st = st_ff;
      if (en_i) begin
         nxt_st.q = d_i;
      end
   end

   generate
      if (CLEARABLE) begin : g_clr
         // clear forces zero without waiting for the clock
         always_ff @(posedge clk_sys_i or negedge rst_n_i or posedge clr_i) begin
            if (!rst_n_i) begin
               st_ff <= '0;
            end else if (clr_i) begin
               st_ff <= '0;
            end else begin
               st_ff <= nxt_st;
            end
         end
      end else begin : g_noclr
         // no asynchronous clear on this bank
         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               st_ff <= '0;
            end else begin
               st_ff <= nxt_st;
            end
         end
      end
   endgenerate

   assign q_o = st_ff.q;
endmodule

//--- testbench/dcr_fabric.sv
// fabric-side clock tick source for the ram block
`timescale 1ns/10ps
module dcr_fabric (
   input  wire logic clk_sys_i,
   input  wire logic slow_i,
   output logic      clk0_en_o,
   output logic      clk1_en_o
);
   logic ph_ff = 1'b0;
   // phase toggle gives the slow output clock
   always_ff @(posedge clk_sys_i) begin
      ph_ff <= ~ph_ff;
   end
   // both clocks tick every cycle, or on opposite phases at half rate when slow
   assign clk0_en_o = !slow_i || !ph_ff;
   assign clk1_en_o = !slow_i || ph_ff;
endmodule

//--- testbench/dcr_ram_chk.sv
// assertion checker for the ram clocking block
`timescale 1ns/10ps
`include "dcr_map.svh"
module dcr_ram_chk
   import dcr_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   clk0_en_i,
   input  wire logic                   clk1_en_i,
   input  dcr_mode_t                   mode_i,
   input  dcr_req_t                    req_a_i,
   input  dcr_req_t                    req_b_i,
   input  dcr_ctl_t                    ctl_a_i,
   input  dcr_ctl_t                    ctl_b_i,
   input  wire logic [`DCR_DATA_W-1:0] dout_a_o,
   input  wire logic [`DCR_DATA_W-1:0] dout_b_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // write on port a, then an output edge that reads it back
   sequence s_wr_a;
      mode_i == DCR_IO && clk0_en_i && ctl_a_i.ce_in && !ctl_a_i.clr_in && req_a_i.wren;
   endsequence
   sequence s_rd_a;
      clk1_en_i && ctl_a_i.ce_out && !ctl_a_i.clr_out && !ctl_a_i.clr_in;
   endsequence
   property p_io_rd;
      s_wr_a ##1 s_rd_a |=> ctl_a_i.clr_out || dout_a_o == $past(req_a_i.data, 2);
   endproperty
   property p_hold_a;
      mode_i == DCR_IO && !(clk1_en_i && ctl_a_i.ce_out) |=> $stable(dout_a_o) || ctl_a_i.clr_out;
   endproperty
   property p_hold_b;
      mode_i == DCR_IO && !(clk1_en_i && ctl_b_i.ce_out) |=> $stable(dout_b_o) || ctl_b_i.clr_out;
   endproperty
   property p_clr_a;
      ctl_a_i.clr_out |-> dout_a_o == 8'h00;
   endproperty
   property p_clr_b;
      ctl_b_i.clr_out |-> dout_b_o == 8'h00;
   endproperty
   property p_sp_idle;
      mode_i == DCR_SP |=> $stable(dout_b_o) || ctl_b_i.clr_out;
   endproperty
   property p_rw_idle;
      mode_i == DCR_RW |=> $stable(dout_a_o) || ctl_a_i.clr_out;
   endproperty
   property p_rst;
      $rose(rst_n_i) |-> (dout_a_o == 8'h00 && dout_b_o == 8'h00)[*2];
   endproperty
   a_io_rd: assert property (p_io_rd) else $error("read after write wrong");
   a_hold_a: assert property (p_hold_a) else $error("port a out moved");
   a_hold_b: assert property (p_hold_b) else $error("port b out moved");
   a_clr_a: assert property (p_clr_a) else $error("port a clear failed");
   a_clr_b: assert property (p_clr_b) else $error("port b clear failed");
   a_sp_idle: assert property (p_sp_idle) else $error("port b active");
   a_rw_idle: assert property (p_rw_idle) else $error("port a out active");
   a_rst: assert property (p_rst) else $error("output not zero");
endmodule
bind dcr_ram dcr_ram_chk u_dcr_ram_chk (.clk_sys_i, .rst_n_i, .clk0_en_i, .clk1_en_i, .mode_i,
   .req_a_i, .req_b_i, .ctl_a_i, .ctl_b_i, .dout_a_o, .dout_b_o);

//--- testbench/testbench.sv
// self-checking bench for the ram clocking block
`timescale 1ns/10ps
`include "dcr_map.svh"
module testbench;
   import dcr_pkg::*;
   logic      clk_sys_i = 1'b0;
   logic      rst_n_i = 1'b0;
   logic      slow = 1'b0;
   logic      c0;
   logic      c1;
   dcr_mode_t mode = DCR_IO;
   dcr_req_t  ra = '0;
   dcr_req_t  rb = '0;
   dcr_ctl_t  ca = 4'hC;
   dcr_ctl_t  cb = 4'hC;
   logic [7:0] da;
   logic [7:0] db;
   int        failures = 0;
   int        samples_checked = 0;
   // clock
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   dcr_fabric u_dcr_fabric (.clk_sys_i(clk_sys_i), .slow_i(slow), .clk0_en_o(c0), .clk1_en_o(c1));
   dcr_ram u_dcr_ram (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk0_en_i(c0), .clk1_en_i(c1), .mode_i(mode),
      .req_a_i(ra), .req_b_i(rb), .ctl_a_i(ca), .ctl_b_i(cb), .dout_a_o(da), .dout_b_o(db));
   function automatic dcr_req_t w(input logic [8:0] ad, input logic [7:0] d);
      return '{1'b1, 1'b1, ad, d};
   endfunction
   function automatic dcr_req_t r(input logic [8:0] ad);
      return '{1'b0, 1'b1, ad, 8'h00};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // drive both ports at the falling edge, then let n cycles pass
   task automatic go(input dcr_req_t a, input dcr_req_t b, input int n);
      ra = a;
      rb = b;
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic t_io;
      go(w(9'h005, 8'h3C), w(9'h1FF, 8'hA5), 1);
      go(r(9'h1FF), r(9'h005), 3);
      chk(da, 8'hA5);
      chk(db, 8'h3C);
      ca = 4'h8;
      cb = 4'h8;
      go(r(9'h005), r(9'h1FF), 3);
      chk(da, 8'hA5);
      chk(db, 8'h3C);
      ca = 4'h4;
      cb = 4'hC;
      go(w(9'h005, 8'hEE), r(9'h1FF), 3);
      ca = 4'hD;
      go(r(9'h005), r(9'h1FF), 1);
      chk(da, 8'h00);
      ca = 4'hC;
      go(r(9'h005), r(9'h1FF), 3);
      chk(da, 8'h3C);
      go(w(9'h000, 8'h6B), r(9'h1FF), 1);
      go(r(9'h005), r(9'h1FF), 1);
      ca = 4'hE;
      go(w(9'h005, 8'h55), r(9'h1FF), 2);
      chk(da, 8'h6B);
      ca = 4'hC;
      go(r(9'h005), r(9'h1FF), 2);
      chk(da, 8'h3C);
      $display("test io done");
   endtask
   task automatic t_rw;
      mode = DCR_RW;
      slow = 1'b1;
      go(w(9'h010, 8'h77), w(9'h005, 8'h99), 2);
      go(r(9'h000), r(9'h010), 4);
      chk(db, 8'h77);
      go(r(9'h000), r(9'h005), 4);
      chk(db, 8'h3C);
      cb = 4'hD;
      go(r(9'h000), r(9'h005), 1);
      chk(db, 8'h00);
      cb = 4'hC;
      $display("test rw done");
   endtask
   task automatic t_sp;
      mode = DCR_SP2;
      slow = 1'b0;
      go(w(9'h003, 8'h5A), w(9'h003, 8'hC3), 1);
      go(r(9'h003), r(9'h003), 3);
      chk(da, 8'h5A);
      chk(db, 8'hC3);
      mode = DCR_SP;
      go(w(9'h004, 8'h21), w(9'h004, 8'h42), 1);
      go(r(9'h004), r(9'h004), 3);
      chk(da, 8'h21);
      chk(db, 8'hC3);
      $display("test sp done");
   endtask
   task automatic report_and_stop;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // reset, then the tests in turn
   initial begin
      repeat (8) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      t_io;
      t_rw;
      t_sp;
      report_and_stop;
   end
   // watchdog: tests need under 100 cycles, allow 2000
   initial begin
      #10000;
      failures++;
      report_and_stop;
   end
endmodule
